// ### autoneg_np_pkg.sv
package autoneg_np_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [4:0]  ADDR_EXPANSION      = 5'h06;
  localparam logic [4:0]  ADDR_NP_TRANSMIT    = 5'h07;
  localparam logic [4:0]  ADDR_PARTNER_NP_RX  = 5'h08;

  // ****************************************
  // expansion register fields
  // ****************************************
  localparam int          EXP_BASE_PAGE       = 5;
  localparam int          EXP_PAR_DET_FAULT   = 4;
  localparam int          EXP_PARTNER_NP_ABLE = 3;
  localparam int          EXP_LOCAL_NP_ABLE   = 2;
  localparam int          EXP_PAGE_RECEIVED   = 1;
  localparam int          EXP_PARTNER_AN_ABLE = 0;
  localparam logic        LOCAL_NP_ABLE_RESET = 1'b1;

  // ****************************************
  // next page word fields
  // ****************************************
  localparam int          NP_MORE_PAGES       = 15;
  localparam int          NP_ACK              = 14;
  localparam int          NP_MESSAGE          = 13;
  localparam int          NP_COMPLY           = 12;
  localparam int          NP_TOGGLE           = 11;
  localparam int          NP_CODE_MSB         = 10;
  localparam int          CODE_WIDTH          = 11;

  localparam logic        MORE_PAGES_RESET    = 1'b0;
  localparam logic        MESSAGE_RESET       = 1'b1;
  localparam logic        COMPLY_RESET        = 1'b0;
  localparam logic        TOGGLE_RESET        = 1'b0;
  localparam logic [10:0] CODE_RESET          = 11'h001;
  localparam logic [15:0] PARTNER_NP_RESET    = 16'h0000;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic        stored;
    logic        is_next;
    logic [15:0] word;
  } rx_page_t;

  typedef struct packed {
    logic        more_pages_follow;
    logic        message_page_flag;
    logic        comply_ack_flag;
    logic        toggle;
    logic [10:0] code;
  } tx_np_t;

endpackage

// ### autoneg_np_regs.sv
`timescale 1ns/1ns
`default_nettype none

// Operation
// R1: base page flag latches high from the negotiation base page variable.
// R2: base page flag only sets while the alternate next page feature is on.
// R3: parallel detection fault flag latches high on a fault, else zero.
// R4: read-only bit shows partner next page capability.
// R5: read-only bit shows local next page capability, reset value one.
// R6: page received latches high when a page word has been stored.
// R7: reading the expansion register clears page received.
// R8: with alternate feature, page received clears on page_rx fall or tx disable rise.
// R9: read-only bit shows partner auto-negotiation capability.
// R10: software sets more pages follow; device transmits that value.
// R11: software writes zero to reserved bit 14 and ignores it on read.
// R12: transmit message page flag marks message or unformatted page, resets one.
// R13: transmit comply acknowledge flag, resets zero.
// R14: toggle bit is inverse of previous transmitted toggle, both directions; a transmit register write loads toggle from bit 11 unless tx_page_sent.
// R15: received register reports partner more pages follow, read-only.
// R16: received acknowledge bit reports partner got our code word.
// R17: received message page flag reports partner page type.
// R18: received comply acknowledge flag reports partner compliance.
// R19: alternate next page feature enables alternate behaviour when one.
// R20: writes to read-only fields never change stored values.
module autoneg_np_regs
  import autoneg_np_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [4:0]  reg_addr,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  input  wire logic [15:0] reg_wdata,
  output var  logic [15:0] reg_rdata,
  output var  logic        reg_rvalid,
  input  wire logic        alt_next_page_feature,
  input  wire logic        base_page_var,
  input  wire logic        par_det_fault,
  input  wire logic        partner_np_able,
  input  wire logic        partner_an_able,
  input  wire logic        mr_page_rx,
  input  wire logic        transmit_disable,
  input  wire rx_page_t    rx_page,
  input  wire logic        tx_page_sent,
  output var  tx_np_t      tx_page,
  output var  logic        page_received
);

  // ****************************************
  // state
  // ****************************************
  logic        base_page_flag;
  logic        fault_flag;
  logic        page_rx_flag;
  logic        local_np_able;
  logic        page_rx_prev;
  logic        tx_dis_prev;
  logic [15:0] partner_np;
  logic        next_base_page_flag;
  logic        next_fault_flag;
  logic        next_page_rx_flag;
  logic        next_page_received;
  logic        next_local_np_able;
  logic        next_page_rx_prev;
  logic        next_tx_dis_prev;
  tx_np_t      next_tx_page;
  logic [15:0] next_partner_np;
  logic [15:0] next_reg_rdata;
  logic        next_reg_rvalid;
  logic        exp_read;
  logic        np_write;
  logic        page_rx_fall;
  logic        tx_dis_rise;
  logic        alt_clear;
  logic        base_page_set;
  logic        next_store;

  // ****************************************
  // functions
  // ****************************************
  function automatic logic hit(
    input logic [4:0] addr,
    input logic [4:0] target,
    input logic       strobe
  );
    hit = strobe && (addr == target);
  endfunction

  function automatic logic latch_high(
    input logic held,
    input logic clear,
    input logic set
  );
    latch_high = set || (held && !clear);
  endfunction

  function automatic logic [15:0] tx_word(input tx_np_t t);
    tx_word = {t.more_pages_follow, 1'b0, t.message_page_flag, t.comply_ack_flag, t.toggle, t.code};
  endfunction

  function automatic logic [15:0] expansion_word(
    input logic base_page,
    input logic fault,
    input logic partner_next,
    input logic local_next,
    input logic page_rx,
    input logic partner_an
  );
    expansion_word                      = 16'h0000;
    expansion_word[EXP_BASE_PAGE]       = base_page;
    expansion_word[EXP_PAR_DET_FAULT]   = fault;
    expansion_word[EXP_PARTNER_NP_ABLE] = partner_next;
    expansion_word[EXP_LOCAL_NP_ABLE]   = local_next;
    expansion_word[EXP_PAGE_RECEIVED]   = page_rx;
    expansion_word[EXP_PARTNER_AN_ABLE] = partner_an;
  endfunction

  // ****************************************
  // access decode
  // ****************************************
  always_comb begin
    exp_read      = hit(reg_addr, ADDR_EXPANSION, reg_read);  // see R7
    np_write      = hit(reg_addr, ADDR_NP_TRANSMIT, reg_write);  // see R20
    base_page_set = alt_next_page_feature && base_page_var;  // see R2 see R19
    next_store    = rx_page.stored && rx_page.is_next;  // see R6
    page_rx_fall  = page_rx_prev && !mr_page_rx;
    tx_dis_rise   = !tx_dis_prev && transmit_disable;
    alt_clear     = alt_next_page_feature && (page_rx_fall || tx_dis_rise);  // see R8 see R19
  end

  // ****************************************
  // edge history
  // ****************************************
  always_comb begin
    next_page_rx_prev = mr_page_rx;
    next_tx_dis_prev  = transmit_disable;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      page_rx_prev <= 1'b0;
      tx_dis_prev  <= 1'b0;
    end else begin
      page_rx_prev <= next_page_rx_prev;
      tx_dis_prev  <= next_tx_dis_prev;
    end
  end

  // ****************************************
  // base page flag
  // ****************************************
  always_comb begin
    next_base_page_flag = latch_high(base_page_flag, exp_read, base_page_set);  // see R1 see R2
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      base_page_flag <= 1'b0;
    end else begin
      base_page_flag <= next_base_page_flag;
    end
  end

  // ****************************************
  // parallel detection fault flag
  // ****************************************
  always_comb begin
    next_fault_flag = latch_high(fault_flag, exp_read, par_det_fault);  // see R3
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      fault_flag <= 1'b0;
    end else begin
      fault_flag <= next_fault_flag;
    end
  end

  // ****************************************
  // page received flag
  // ****************************************
  always_comb begin
    next_page_rx_flag  = latch_high(page_rx_flag, exp_read || alt_clear, rx_page.stored);  // see R6 see R7 see R8
    next_page_received = next_page_rx_flag;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      page_rx_flag  <= 1'b0;
      page_received <= 1'b0;
    end else begin
      page_rx_flag  <= next_page_rx_flag;
      page_received <= next_page_received;
    end
  end

  // ****************************************
  // local next page ability
  // ****************************************
  always_comb begin
    next_local_np_able = local_np_able;  // see R5 see R20
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      local_np_able <= LOCAL_NP_ABLE_RESET;
    end else begin
      local_np_able <= next_local_np_able;
    end
  end

  // ****************************************
  // partner next page word
  // ****************************************
  always_comb begin
    // base pages are not stored
    next_partner_np = partner_np;  // see R20
    if (next_store) begin  // see R6 see R15 see R16 see R17 see R18
      next_partner_np = rx_page.word;  // see R14
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      partner_np <= PARTNER_NP_RESET;
    end else begin
      partner_np <= next_partner_np;
    end
  end

  // ****************************************
  // transmit next page
  // ****************************************
  always_comb begin
    // reserved bit 14 not stored
    next_tx_page = tx_page;
    if (np_write) begin  // see R10 see R11 see R12 see R13
      next_tx_page.more_pages_follow = reg_wdata[NP_MORE_PAGES];
      next_tx_page.message_page_flag = reg_wdata[NP_MESSAGE];
      next_tx_page.comply_ack_flag   = reg_wdata[NP_COMPLY];
      next_tx_page.toggle            = reg_wdata[NP_TOGGLE];
      next_tx_page.code              = reg_wdata[NP_CODE_MSB:0];
    end
    if (tx_page_sent) begin
      next_tx_page.toggle = ~tx_page.toggle;  // see R14
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_page <= '{MORE_PAGES_RESET, MESSAGE_RESET, COMPLY_RESET, TOGGLE_RESET, CODE_RESET};
    end else begin
      tx_page <= next_tx_page;
    end
  end

  // ****************************************
  // read data
  // ****************************************
  always_comb begin
    next_reg_rdata = reg_rdata;
    if (reg_read) begin
      unique case (reg_addr)
        ADDR_EXPANSION: begin
          next_reg_rdata = expansion_word(base_page_flag, fault_flag, partner_np_able, local_np_able,
                                          page_rx_flag, partner_an_able);  // see R4 see R5 see R9
        end
        ADDR_NP_TRANSMIT: begin
          next_reg_rdata = tx_word(tx_page);
        end
        ADDR_PARTNER_NP_RX: begin
          next_reg_rdata = partner_np;  // see R14
        end
        default: begin
          next_reg_rdata = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // ****************************************
  // read valid
  // ****************************************
  always_comb begin
    next_reg_rvalid = reg_read;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= next_reg_rvalid;
    end
  end

endmodule

`default_nettype wire

// ### autoneg_np_partner.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// remote link partner
// ****
module autoneg_np_partner
  import autoneg_np_pkg::*;
(
  input  wire logic     clk,
  output var  rx_page_t rx_page,
  output var  logic     tx_page_sent
);
  logic tgl = 1'b0;
  initial begin
    rx_page = '0;
    tx_page_sent = 1'b0;
  end
  task automatic page(input logic nx, input logic [15:0] w);
    @(negedge clk);
    rx_page = {1'b1, nx, w[15:12], tgl, w[10:0]};
    tgl = ~tgl;
    @(negedge clk);
    rx_page = {1'b0, ~nx, ~w};
  endtask
  task automatic sent;
    @(negedge clk);
    tx_page_sent = 1'b1;
    @(negedge clk);
    tx_page_sent = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### autoneg_np_regs_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// port checks
// ****
module autoneg_np_regs_monitor
  import autoneg_np_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [4:0]  reg_addr,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_rvalid,
  input wire rx_page_t    rx_page,
  input wire logic        tx_page_sent,
  input wire tx_np_t      tx_page,
  input wire logic        page_received
);
  logic [15:0] wd_q;
  logic [4:0]  a_q;
  always_ff @(posedge clk) begin
    wd_q <= reg_wdata;
    a_q  <= reg_addr;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  page_set_a: assert property (rx_page.stored |=> page_received) else $error("flag not set");
  page_cause_a: assert property ($rose(page_received) |-> $past(rx_page.stored))
    else $error("flag without page");
  read_clear_a: assert property (reg_read && reg_addr == ADDR_EXPANSION && !rx_page.stored
    |=> !page_received) else $error("flag not cleared");
  toggle_flip_a: assert property (tx_page_sent |=> $changed(tx_page.toggle))
    else $error("toggle kept");
  tx_write_a: assert property (reg_write && reg_addr == ADDR_NP_TRANSMIT && !tx_page_sent
    |=> tx_page == {wd_q[15], wd_q[13:0]}) else $error("tx word wrong");
  tx_hold_a: assert property (!(reg_write && reg_addr == ADDR_NP_TRANSMIT) && !tx_page_sent
    |=> $stable(tx_page)) else $error("tx word moved");
  exp_read_a: assert property (reg_rvalid && a_q == ADDR_EXPANSION
    |-> reg_rdata[15:6] == 10'h000 && reg_rdata[2]) else $error("expansion bits wrong");
  tx_read_a: assert property (reg_rvalid && a_q == ADDR_NP_TRANSMIT |-> !reg_rdata[14])
    else $error("bit 14 set");
  rvalid_pulse_a: assert property (reg_rvalid == $past(reg_read))
    else $error("read valid wrong");
endmodule
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
  import autoneg_np_pkg::*;
;
  // ****
  // stimulus and checks
  // ****
  typedef struct packed {
    logic [4:0]  a;
    logic [15:0] w;
    logic [15:0] e;
  } row_t;
  row_t rows [5] = '{'{5'h07, 16'hbfff, 16'hbfff}, '{5'h07, 16'h1a5a, 16'h1a5a},
    '{5'h06, 16'hffff, 16'h0004}, '{5'h08, 16'hffff, 16'h0000}, '{5'h1f, 16'h1234, 16'h0000}};
  logic        clk, reset, reg_write, reg_read, reg_rvalid, page_received, tx_page_sent;
  logic        alt_next_page_feature, base_page_var, par_det_fault;
  logic        partner_np_able, partner_an_able, mr_page_rx, transmit_disable;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  rx_page_t    rx_page;
  tx_np_t      tx_page;
  int          err_total, n_compared;
  autoneg_np_regs i_autoneg_np_regs (.*);
  autoneg_np_partner i_autoneg_np_partner (.*);
  task automatic wr(input logic [4:0] a, input logic [15:0] w);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = w;
    reg_write = 1'b1;
    @(negedge clk);
    reg_write = 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(negedge clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clk);
    reg_read = 1'b0;
    n_compared++;
    if (reg_rdata !== e) begin
      err_total++;
      $display("MISMATCH %0t %h %h", $time, reg_rdata, e);
    end
  endtask
  task automatic close_out;
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #100000;
    err_total++;
    close_out;
  end
  initial begin
    {reg_write, reg_read, alt_next_page_feature, base_page_var, par_det_fault} = '0;
    {partner_np_able, partner_an_able, mr_page_rx, transmit_disable, reg_addr, reg_wdata} = '0;
    {err_total, n_compared} = '0;
    reset = 1'b1;
    repeat (6) @(negedge clk);
    reset = 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].e);
    end
    reset = 1'b1;
    @(negedge clk);
    reset = 1'b0;
    rd(ADDR_NP_TRANSMIT, 16'h2001);
    i_autoneg_np_partner.sent();
    rd(ADDR_NP_TRANSMIT, 16'h2801);
    {mr_page_rx, partner_np_able, partner_an_able, par_det_fault, base_page_var} = 5'h1f;
    i_autoneg_np_partner.page(1'b1, 16'hd555);
    par_det_fault = 1'b0;
    rd(ADDR_PARTNER_NP_RX, 16'hd555);
    rd(ADDR_EXPANSION, 16'h001f);
    rd(ADDR_EXPANSION, 16'h000d);
    alt_next_page_feature = 1'b1;
    i_autoneg_np_partner.page(1'b0, 16'h0000);
    {base_page_var, mr_page_rx} = 2'b00;
    @(negedge clk);
    rd(ADDR_EXPANSION, 16'h002d);
    i_autoneg_np_partner.page(1'b1, 16'h4321);
    transmit_disable = 1'b1;
    @(negedge clk);
    rd(ADDR_EXPANSION, 16'h000d);
    rd(ADDR_PARTNER_NP_RX, 16'h4321);
    close_out;
  end
endmodule
bind autoneg_np_regs autoneg_np_regs_monitor i_autoneg_np_regs_monitor (.*);
`default_nettype wire
